// [hdl/diag_router_pkg.sv]
package diag_router_pkg;
   localparam int unsigned NUM_SIG   = 4;
   localparam int unsigned WORD_W    = 32;
   localparam int unsigned PRI_W     = 4;
   localparam int unsigned SEL_W     = 5;
   localparam int unsigned NUM_W     = 10;
   localparam int unsigned CFG_W     = 4;
   // Parameter index of each resource-block setting
   localparam logic [SEL_W-1:0] SEL_MAP_BASE  = 5'h00;
   localparam logic [SEL_W-1:0] SEL_PRI_BASE  = 5'h04;
   localparam logic [SEL_W-1:0] SEL_DET_BASE  = 5'h08;
   localparam logic [SEL_W-1:0] SEL_MASK_BASE = 5'h0c;
   localparam logic [SEL_W-1:0] SEL_FEATURE   = 5'h10;
   // Status signal order
   localparam logic [1:0] SIG_FAIL    = 2'h0;
   localparam logic [1:0] SIG_CHECK   = 2'h1;
   localparam logic [1:0] SIG_OFFSPEC = 2'h2;
   localparam logic [1:0] SIG_MAINT   = 2'h3;
   // Event number range limits
   localparam logic [NUM_W-1:0] SENSOR_MAX = 10'h0c7;
   localparam logic [NUM_W-1:0] ELEC_MAX   = 10'h18f;
   localparam logic [NUM_W-1:0] CONFIG_MAX = 10'h2bc;
   localparam logic [NUM_W-1:0] PROC_MIN   = 10'h320;
   localparam logic [NUM_W-1:0] PROC_MAX   = 10'h3e7;
   // Map word layout
   localparam int unsigned RANGE_TOP      = 31;
   localparam int unsigned GROUP_SPAN     = 4;
   localparam logic [WORD_W-1:0] AREA_MASK = 32'h0000_fffe;
   localparam logic [WORD_W-1:0] WRITE_MASK = 32'hffff_fffe;
   // Reset values, priority thresholds and the no-area code
   localparam logic [WORD_W-1:0] MAP_FAIL_RST    = 32'hf000_0000;
   localparam logic [WORD_W-1:0] MAP_CHECK_RST   = 32'h0f00_0000;
   localparam logic [WORD_W-1:0] MAP_OFFSPEC_RST = 32'h00f0_0000;
   localparam logic [WORD_W-1:0] MAP_MAINT_RST   = 32'h000f_0000;
   localparam logic [WORD_W-1:0] DET_RST         = 32'hffff_fffe;
   localparam logic [WORD_W-1:0] MASK_RST        = 32'h0000_0000;
   localparam logic [PRI_W-1:0]  PRI_RST         = 4'h0;
   localparam logic [PRI_W-1:0]  PRI_DISPLAY     = 4'h1;
   localparam logic [PRI_W-1:0]  PRI_SEND_MIN    = 4'h2;
   localparam logic [CFG_W-1:0]  CFG_NONE        = 4'h0;
   // Severity groups; low weighting has two groups
   typedef enum logic [1:0] {
      GRP_HIGHEST,
      GRP_HIGH,
      GRP_LOW_SPEC,
      GRP_LOW_MAINT
   } group_t;
endpackage

// [hdl/field_diagnostic_status_router.sv]
`timescale 1ns/10ps
`default_nettype none
module field_diagnostic_status_router
   import diag_router_pkg::*;
(
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               srst,
   // Parameter access
   input  wire logic               wr_en,
   input  wire logic [SEL_W-1:0]   wr_sel,
   input  wire logic [WORD_W-1:0]  wr_data,
   input  wire logic               rd_en,
   input  wire logic [SEL_W-1:0]   rd_sel,
   output logic                    rd_valid,
   output logic      [WORD_W-1:0]  rd_data,
   // Diagnostic event in
   input  wire logic               event_valid,
   input  wire logic [NUM_W-1:0]   event_num,
   input  wire logic [1:0]         event_group,
   input  wire logic [CFG_W-1:0]   event_area,
   // Routed event out
   output logic                    route_valid,
   output logic      [NUM_W-1:0]   route_num,
   output logic      [NUM_SIG-1:0] route_status,
   output logic      [NUM_SIG-1:0] route_display,
   output logic      [NUM_SIG-1:0] route_send,
   output logic                    feature_on
);

   logic [WORD_W-1:0] map_r    [NUM_SIG];
   logic [WORD_W-1:0] map_nxt  [NUM_SIG];
   logic [WORD_W-1:0] det_r    [NUM_SIG];
   logic [WORD_W-1:0] det_nxt  [NUM_SIG];
   logic [WORD_W-1:0] mask_r   [NUM_SIG];
   logic [WORD_W-1:0] mask_nxt [NUM_SIG];
   logic [PRI_W-1:0]  pri_r    [NUM_SIG];
   logic [PRI_W-1:0]  pri_nxt  [NUM_SIG];
   logic              feature_r;
   logic              feature_nxt;
   logic              rd_valid_r;
   logic              rd_valid_nxt;
   logic [WORD_W-1:0] rd_data_r;
   logic [WORD_W-1:0] rd_data_nxt;
   logic              route_valid_r;
   logic              route_valid_nxt;
   logic [NUM_W-1:0]  route_num_r;
   logic [NUM_W-1:0]  route_num_nxt;
   logic [NUM_SIG-1:0] status_r;
   logic [NUM_SIG-1:0] status_nxt;
   logic [NUM_SIG-1:0] display_r;
   logic [NUM_SIG-1:0] display_nxt;
   logic [NUM_SIG-1:0] send_r;
   logic [NUM_SIG-1:0] send_nxt;
   logic [WORD_W-1:0]  ev_bits;

   function automatic logic [WORD_W-1:0] reset_map(input int unsigned s);
      case (s)
         0:       reset_map = MAP_FAIL_RST;
         1:       reset_map = MAP_CHECK_RST;
         2:       reset_map = MAP_OFFSPEC_RST;
         default: reset_map = MAP_MAINT_RST;
      endcase
   endfunction

   // One-hot map bit of an event; zero for numbers outside every range unless an area is assigned with the feature on
   function automatic logic [WORD_W-1:0] event_bits(input logic [1:0] grp,
                                                    input logic [NUM_W-1:0] num,
                                                    input logic [CFG_W-1:0] area,
                                                    input logic feat);
      logic [WORD_W-1:0] b;
      int unsigned       cat;
      logic              ok;
      b   = '0;
      cat = 0;
      ok  = 1'b1;
      // Numbers 701 to 799 and above 999 fall in no range
      if (num <= SENSOR_MAX) begin
         cat = 0;
      end else if (num <= ELEC_MAX) begin
         cat = 1;
      end else if (num <= CONFIG_MAX) begin
         cat = 2;
      end else if (num >= PROC_MIN && num <= PROC_MAX) begin
         cat = 3;
      end else begin
         ok = 1'b0;
      end
      // Area assignment replaces the range bit, only with the feature on
      if (feat && area != CFG_NONE) begin
         b[area] = 1'b1;
      end else if (ok) begin
         b[RANGE_TOP - int'(grp) * GROUP_SPAN - cat] = 1'b1;
      end
      return b;
   endfunction

   // Parameter file
   always_comb begin
      for (int s = 0; s < NUM_SIG; s++) begin
         map_nxt[s]  = map_r[s];
         det_nxt[s]  = det_r[s];
         mask_nxt[s] = mask_r[s];
         pri_nxt[s]  = pri_r[s];
         if (wr_en && wr_sel == SEL_MAP_BASE + SEL_W'(s)) begin
            map_nxt[s] = wr_data & WRITE_MASK;
         end
         if (wr_en && wr_sel == SEL_DET_BASE + SEL_W'(s)) begin
            det_nxt[s] = wr_data & WRITE_MASK;
         end
         if (wr_en && wr_sel == SEL_MASK_BASE + SEL_W'(s)) begin
            mask_nxt[s] = wr_data & WRITE_MASK;
         end
         if (wr_en && wr_sel == SEL_PRI_BASE + SEL_W'(s)) begin
            pri_nxt[s] = wr_data[PRI_W-1:0];
         end
      end
      feature_nxt = feature_r;
      if (wr_en && wr_sel == SEL_FEATURE) begin
         feature_nxt = wr_data[0];
      end
      rd_valid_nxt = rd_en;
      rd_data_nxt  = '0;
      if (rd_en) begin
         for (int s = 0; s < NUM_SIG; s++) begin
            if (rd_sel == SEL_MAP_BASE + SEL_W'(s)) begin
               rd_data_nxt = map_r[s];
            end
            if (rd_sel == SEL_DET_BASE + SEL_W'(s)) begin
               rd_data_nxt = det_r[s];
            end
            if (rd_sel == SEL_MASK_BASE + SEL_W'(s)) begin
               rd_data_nxt = mask_r[s];
            end
            if (rd_sel == SEL_PRI_BASE + SEL_W'(s)) begin
               rd_data_nxt = {{(WORD_W-PRI_W){1'b0}}, pri_r[s]};
            end
         end
         if (rd_sel == SEL_FEATURE) begin
            rd_data_nxt = {{(WORD_W-1){1'b0}}, feature_r};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         for (int s = 0; s < NUM_SIG; s++) begin
            map_r[s]  <= reset_map(s);
            det_r[s]  <= DET_RST;
            mask_r[s] <= MASK_RST;
            pri_r[s]  <= PRI_RST;
         end
         feature_r  <= 1'b0;
         rd_valid_r <= 1'b0;
         rd_data_r  <= '0;
      end else begin
         for (int s = 0; s < NUM_SIG; s++) begin
            map_r[s]  <= map_nxt[s];
            det_r[s]  <= det_nxt[s];
            mask_r[s] <= mask_nxt[s];
            pri_r[s]  <= pri_nxt[s];
         end
         feature_r  <= feature_nxt;
         rd_valid_r <= rd_valid_nxt;
         rd_data_r  <= rd_data_nxt;
      end
   end

   // Routing is resolved once at occurrence, so later map edits never touch it
   always_comb begin
      logic [WORD_W-1:0] m;
      m               = '0;
      ev_bits         = event_bits(event_group, event_num, event_area, feature_r);
      route_valid_nxt = event_valid;
      route_num_nxt   = event_valid ? event_num : route_num_r;
      status_nxt      = '0;
      display_nxt     = '0;
      send_nxt        = '0;
      for (int s = 0; s < NUM_SIG; s++) begin
         // Legacy routing uses factory maps while the feature is off
         m = feature_r ? map_r[s] : reset_map(s);
         status_nxt[s]  = event_valid && |(m & ev_bits);
         display_nxt[s] = status_nxt[s] && |(det_r[s] & ev_bits)
                          && pri_r[s] >= PRI_DISPLAY;
         send_nxt[s]    = display_nxt[s] && |(~mask_r[s] & ev_bits)
                          && pri_r[s] >= PRI_SEND_MIN;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         route_valid_r <= 1'b0;
         route_num_r   <= '0;
         status_r      <= '0;
         display_r     <= '0;
         send_r        <= '0;
      end else begin
         route_valid_r <= route_valid_nxt;
         route_num_r   <= route_num_nxt;
         status_r      <= status_nxt;
         display_r     <= display_nxt;
         send_r        <= send_nxt;
      end
   end

   assign rd_valid      = rd_valid_r;
   assign rd_data       = rd_data_r;
   assign route_valid   = route_valid_r;
   assign route_num     = route_num_r;
   assign route_status  = status_r;
   assign route_display = display_r;
   assign route_send    = send_r;
   assign feature_on    = feature_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   legacy_route_a: assert property (
      (event_valid && !feature_r && event_num <= SENSOR_MAX
       && event_group == GRP_HIGHEST) |=> route_status == 4'h1)
      else $error("legacy routing wrong");
   range_route_a: assert property (
      (event_valid && feature_r && event_area == CFG_NONE && event_num > ELEC_MAX
       && event_num <= CONFIG_MAX && event_group == GRP_HIGH)
      |=> route_status[SIG_FAIL] == $past(map_r[SIG_FAIL][25]))
      else $error("range bit not honoured");
   no_signal_a: assert property (
      (event_valid && event_num > CONFIG_MAX && event_num < PROC_MIN
       && (!feature_r || event_area == CFG_NONE)) |=> route_status == 4'h0)
      else $error("gap number produced a signal");
   area_route_a: assert property (
      (event_valid && feature_r && event_area != CFG_NONE)
      |=> route_status[SIG_MAINT] == $past(map_r[SIG_MAINT][event_area]))
      else $error("area bit not honoured");
   pri_zero_a: assert property (
      (event_valid && pri_r[SIG_CHECK] == PRI_RST) |=> !route_display[SIG_CHECK])
      else $error("priority zero event displayed");
   pri_one_a: assert property (
      (event_valid && pri_r[SIG_FAIL] == PRI_DISPLAY) |=> !route_send[SIG_FAIL])
      else $error("priority one event sent");
   send_chain_a: assert property (
      route_send[SIG_OFFSPEC] |-> route_display[SIG_OFFSPEC]
      && $past(pri_r[SIG_OFFSPEC]) >= PRI_SEND_MIN)
      else $error("send without display or priority");
   mask_block_a: assert property (
      (event_valid && (mask_r[SIG_OFFSPEC] & ev_bits) != '0) |=> !route_send[SIG_OFFSPEC])
      else $error("masked event sent");
   detect_gate_a: assert property (
      (event_valid && (det_r[SIG_OFFSPEC] & ev_bits) == '0) |=> !route_display[SIG_OFFSPEC])
      else $error("undetected event recorded");
   bit_zero_a: assert property (
      (wr_en && wr_sel == SEL_MAP_BASE) |=> !map_r[SIG_FAIL][0])
      else $error("reserved bit stored");
   hold_route_a: assert property (
      (route_valid && !event_valid) |=> $stable(route_num))
      else $error("routed number changed without event");
   // Reset values are checked during reset itself, so the default disable is lifted
   feature_reset_a: assert property (
      disable iff (1'b0) srst |=> !feature_r)
      else $error("feature not off after reset");
   map_reset_a: assert property (
      disable iff (1'b0) srst |=> map_r[SIG_FAIL] == MAP_FAIL_RST
      && map_r[SIG_CHECK] == MAP_CHECK_RST && map_r[SIG_OFFSPEC] == MAP_OFFSPEC_RST
      && map_r[SIG_MAINT] == MAP_MAINT_RST)
      else $error("map reset value wrong");
   pri_reset_a: assert property (
      disable iff (1'b0) srst |=> pri_r[SIG_FAIL] == PRI_RST
      && pri_r[SIG_CHECK] == PRI_RST && pri_r[SIG_OFFSPEC] == PRI_RST
      && pri_r[SIG_MAINT] == PRI_RST)
      else $error("priority reset value wrong");
   sel_reset_a: assert property (
      disable iff (1'b0) srst |=> det_r[SIG_FAIL] == DET_RST && mask_r[SIG_FAIL] == MASK_RST)
      else $error("selection reset value wrong");

   process_range_a: assert property (
      (event_valid && !feature_r && event_num >= PROC_MIN && event_num <= PROC_MAX
       && event_group == GRP_LOW_MAINT) |=> route_status == 4'h8)
      else $error("process range misrouted");
   group_span_a: assert property (
      (event_valid && !feature_r && event_num > ELEC_MAX && event_num <= CONFIG_MAX
       && event_group == GRP_LOW_SPEC) |=> route_status == 4'h4)
      else $error("low group misrouted");
   detect_send_a: assert property (
      (event_valid && (det_r[SIG_OFFSPEC] & ev_bits) == '0) |=> !route_send[SIG_OFFSPEC])
      else $error("undetected event sent");
   status_pulse_a: assert property (
      !route_valid |-> route_status == 4'h0)
      else $error("status without routed event");
   route_pulse_a: assert property (
      event_valid |=> route_valid && route_num == $past(event_num))
      else $error("routed event missing");

   send_seen_c: cover property (event_valid && feature_r ##1 route_send != 4'h0);
   display_only_c: cover property (##1 route_display != 4'h0 && route_send == 4'h0);
   area_used_c: cover property (event_valid && feature_r && event_area != CFG_NONE);
   remap_c: cover property (wr_en && wr_sel == SEL_MAP_BASE ##1 event_valid);
   legacy_c: cover property (event_valid && !feature_r ##1 route_display != 4'h0);

endmodule
`default_nettype wire

// [verification/fieldbus_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module fieldbus_host_model
   import diag_router_pkg::*;
(
   // Clock
   input  wire logic               clk,
   // Parameter writes made by the host
   input  wire logic               wr_en,
   input  wire logic [SEL_W-1:0]   wr_sel,
   input  wire logic               oos_mode,
   // Alarms arriving from the block
   input  wire logic               route_valid,
   input  wire logic [NUM_SIG-1:0] route_send,
   // Tallies
   output var int                  alarm_count,
   output var int                  edit_faults
);
   int alarms = 0;
   int faults = 0;
   always @(posedge clk) begin
      // Only sent alarms reach the host; displayed ones stay local
      if (route_valid && route_send != '0) begin
         alarms <= alarms + 1;
      end
      // Map edits belong inside an out-of-service window
      if (wr_en && wr_sel < SEL_PRI_BASE && !oos_mode) begin
         faults <= faults + 1;
      end
   end
   assign alarm_count = alarms;
   assign edit_faults = faults;
endmodule
`default_nettype wire

// [verification/test_field_diagnostic_status_router.sv]
`timescale 1ns/10ps
`default_nettype none
module test_field_diagnostic_status_router
   import diag_router_pkg::*;
;
   logic               clk = 1'b0;
   logic               srst = 1'b1;
   logic               wr_en = 1'b0;
   logic [SEL_W-1:0]   wr_sel = '0;
   logic [WORD_W-1:0]  wr_data = '0;
   logic               rd_en = 1'b0;
   logic [SEL_W-1:0]   rd_sel = '0;
   logic               event_valid = 1'b0;
   logic [NUM_W-1:0]   event_num = '0;
   logic [1:0]         event_group = '0;
   logic [CFG_W-1:0]   event_area = '0;
   logic               oos_mode = 1'b0;
   logic               rd_valid;
   logic [WORD_W-1:0]  rd_data;
   logic               route_valid;
   logic [NUM_W-1:0]   route_num;
   logic [NUM_SIG-1:0] route_status;
   logic [NUM_SIG-1:0] route_display;
   logic [NUM_SIG-1:0] route_send;
   logic               feature_on;
   int                 fail_count = 0;
   int                 n_checks = 0;
   int                 exp_alarms = 0;
   int                 alarm_count;
   int                 edit_faults;

   field_diagnostic_status_router dut_u (.clk(clk), .srst(srst), .wr_en(wr_en),
      .wr_sel(wr_sel), .wr_data(wr_data), .rd_en(rd_en), .rd_sel(rd_sel),
      .rd_valid(rd_valid), .rd_data(rd_data), .event_valid(event_valid),
      .event_num(event_num), .event_group(event_group), .event_area(event_area),
      .route_valid(route_valid), .route_num(route_num), .route_status(route_status),
      .route_display(route_display), .route_send(route_send), .feature_on(feature_on));

   fieldbus_host_model host_u (.clk(clk), .wr_en(wr_en), .wr_sel(wr_sel),
      .oos_mode(oos_mode), .route_valid(route_valid), .route_send(route_send),
      .alarm_count(alarm_count), .edit_faults(edit_faults));

   always #5 clk = ~clk;

   task automatic check(input logic [39:0] got, input logic [39:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // A posedge passes after each release so strobes never toggle twice at once
   task automatic wr(input logic [4:0] sel, input logic [31:0] d);
      @(negedge clk);
      wr_en = 1'b1;
      wr_sel = sel;
      wr_data = d;
      @(negedge clk);
      wr_en = 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [4:0] sel, input logic [31:0] exp);
      @(negedge clk);
      rd_en = 1'b1;
      rd_sel = sel;
      @(negedge clk);
      check({rd_valid, rd_data}, {1'b1, exp});
      rd_en = 1'b0;
      @(posedge clk);
   endtask

   task automatic ev(input logic [9:0] num, input logic [1:0] grp, input logic [3:0] area,
                     input logic [3:0] st, input logic [3:0] disp, input logic [3:0] snd);
      @(negedge clk);
      event_valid = 1'b1;
      event_num = num;
      event_group = grp;
      event_area = area;
      @(negedge clk);
      check({route_valid, route_num, route_status, route_display, route_send},
            {1'b1, num, st, disp, snd});
      event_valid = 1'b0;
      if (snd != 4'h0) exp_alarms++;
      @(posedge clk);
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      end_of_test();
   end

   initial begin
      repeat (20) @(posedge clk);
      @(negedge clk);
      srst = 1'b0;
      for (int i = 0; i < 4; i++) rd(5'(i), 32'hf000_0000 >> (4 * i));
      for (int i = 4; i < 8; i++) rd(5'(i), 32'h0000_0000);
      rd(5'h08, 32'hffff_fffe);
      rd(5'h0c, 32'h0000_0000);
      rd(5'h10, 32'h0000_0000);
      rd(5'h11, 32'h0000_0000);
      $display("test reset done");
      ev(10'd150, 2'd0, 4'h0, 4'h1, 4'h0, 4'h0);
      wr(5'h04, 32'h0000_0001);
      wr(5'h05, 32'h0000_0002);
      wr(5'h06, 32'h0000_000f);
      wr(5'h07, 32'h0000_0002);
      for (int g = 0; g < 4; g++)
         ev(10'(300 * g), 2'(g), 4'h0, 4'(1 << g), 4'(1 << g), g == 0 ? 4'h0 : 4'(1 << g));
      $display("test priority done");
      // Legacy routing ignores edited maps until the feature is selected
      oos_mode = 1'b1;
      wr(5'h00, 32'hb000_0001);
      wr(5'h01, 32'h4f00_0000);
      oos_mode = 1'b0;
      rd(5'h00, 32'hb000_0000);
      ev(10'd250, 2'd0, 4'h0, 4'h1, 4'h1, 4'h0);
      wr(5'h10, 32'h0000_0001);
      check(feature_on, 1);
      ev(10'd250, 2'd0, 4'h0, 4'h2, 4'h2, 4'h2);
      ev(10'd399, 2'd0, 4'h0, 4'h2, 4'h2, 4'h2);
      ev(10'd199, 2'd0, 4'h0, 4'h1, 4'h1, 4'h0);
      ev(10'd400, 2'd0, 4'h0, 4'h1, 4'h1, 4'h0);
      ev(10'd800, 2'd0, 4'h0, 4'h1, 4'h1, 4'h0);
      ev(10'd600, 2'd1, 4'h0, 4'h2, 4'h2, 4'h2);
      ev(10'd750, 2'd0, 4'h0, 4'h0, 4'h0, 4'h0);
      $display("test range done");
      oos_mode = 1'b1;
      wr(5'h00, 32'h3000_0000);
      wr(5'h02, 32'h00f0_0020);
      oos_mode = 1'b0;
      ev(10'd0, 2'd0, 4'h0, 4'h0, 4'h0, 4'h0);
      ev(10'd10, 2'd0, 4'h5, 4'h4, 4'h4, 4'h4);
      wr(5'h0a, 32'hffff_ffde);
      ev(10'd10, 2'd0, 4'h5, 4'h4, 4'h0, 4'h0);
      wr(5'h0a, 32'hffff_fffe);
      wr(5'h0e, 32'h0000_0021);
      rd(5'h0e, 32'h0000_0020);
      ev(10'd10, 2'd0, 4'h5, 4'h4, 4'h4, 4'h0);
      $display("test area done");
      // Map write and event on one edge: the event sees the old map
      oos_mode = 1'b1;
      @(negedge clk);
      wr_en = 1'b1;
      wr_sel = 5'h01;
      wr_data = 32'h0000_0000;
      event_valid = 1'b1;
      event_num = 10'd250;
      event_area = 4'h0;
      @(negedge clk);
      check({route_status, route_display, route_send}, 12'h222);
      wr_en = 1'b0;
      event_valid = 1'b0;
      exp_alarms++;
      @(posedge clk);
      oos_mode = 1'b0;
      ev(10'd250, 2'd0, 4'h0, 4'h0, 4'h0, 4'h0);
      @(negedge clk);
      check(alarm_count, exp_alarms);
      check(edit_faults, 0);
      $display("test reroute done");
      end_of_test();
   end
endmodule
`default_nettype wire
